// file: tb/pdrc_assertions.sv
// checker: port assertions for the power-down and reset block
`timescale 1ns/10ps
`default_nettype none
module pdrc_chk #(
  parameter int STAB_CYC = 20,
  parameter int FILT_CYC = 4
) (
  input wire logic        clk_sys_in,         // clock
  input wire logic        nrst_in,            // reset
  input wire logic        wb_cyc_in,          // cycle
  input wire logic        wb_stb_in,          // strobe
  input wire logic        wb_we_in,           // write
  input wire logic [7:0]  wb_adr_in,          // offset
  input wire logic [31:0] wb_dat_in,          // wdata
  input wire logic        wb_ack_out,         // ack
  input wire logic        ext_reset_n_pin_in, // pin
  input wire logic        por_in,             // por
  input wire logic        wdt_overflow_in,    // wdt
  input wire logic        wdt_enable_in,      // wdt on
  input wire logic        dbg_reset_in,       // debug
  input wire logic [3:0]  bod_below_in,       // supply
  input wire logic        irq_pending_in,     // irq
  input wire logic        irq_stop_wake_in,   // stop irq
  input wire logic        bit_expired_in,     // timer done
  input wire logic        sys_reset_out,      // int reset
  input wire logic [15:0] reset_vector_out,   // vector
  input wire logic        cpu_halt_out,       // halt
  input wire logic        osc_run_out,        // osc
  input wire logic        periph_clk_en_out,  // pclk
  input wire logic        bit_run_out         // timer run
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  logic [31:0] quiet_r; // cycles with no visible request
  logic [15:0] low_r;   // pin low run
  wire logic   src = por_in | dbg_reset_in | (wdt_overflow_in & wdt_enable_in)
                     | ~ext_reset_n_pin_in | (|bod_below_in);
  wire logic   pwr_wr = wb_cyc_in & wb_stb_in & wb_we_in & wb_ack_out & ~sys_reset_out
                        & (wb_adr_in == pdrc_pkg::PDRC_OFS_PWR);
  always_ff @(posedge clk_sys_in) begin
    quiet_r <= (!nrst_in || src) ? 32'h0 : quiet_r + 32'h1;
    low_r   <= (!nrst_in || ext_reset_n_pin_in) ? 16'h0 : low_r + 16'h1;
  end
  AST_VEC: assert property (reset_vector_out == 16'h0000)
    else $error("reset vector not zero");
  AST_IDLE: assert property (
    pwr_wr && wb_dat_in[7:0] == 8'h01 && !irq_pending_in
    |-> ##[1:3] (cpu_halt_out && osc_run_out && periph_clk_en_out))
    else $error("idle not entered");
  AST_IDLE_WAKE: assert property (
    cpu_halt_out && osc_run_out && irq_pending_in && !sys_reset_out |-> ##[1:3] !cpu_halt_out)
    else $error("idle not left");
  AST_STOP: assert property (
    pwr_wr && wb_dat_in[7:0] == 8'h03 && !irq_stop_wake_in
    |-> ##[1:3] (!osc_run_out && !periph_clk_en_out && !bit_run_out))
    else $error("stop not entered");
  AST_STOP_WAKE: assert property (
    !osc_run_out && irq_stop_wake_in |-> ##[1:3] (osc_run_out && bit_run_out && cpu_halt_out))
    else $error("stop not left");
  AST_BIT_HOLD: assert property (
    cpu_halt_out && bit_run_out && !bit_expired_in && !$past(bit_expired_in)
    && !irq_pending_in && !$past(irq_pending_in) && !sys_reset_out |=> cpu_halt_out)
    else $error("halt ended early");
  AST_RST_SRC: assert property (
    por_in || dbg_reset_in || (wdt_overflow_in && wdt_enable_in) |-> ##[1:2] sys_reset_out)
    else $error("reset source ignored");
  AST_STAB: assert property (
    $fell(sys_reset_out) |-> quiet_r >= STAB_CYC + 4 && quiet_r <= STAB_CYC + 12)
    else $error("reset released at wrong time");
  AST_PIN_SHORT: assert property (
    $rose(ext_reset_n_pin_in) && low_r < FILT_CYC && !sys_reset_out |=> !sys_reset_out [*4])
    else $error("short pin pulse gave reset");
endmodule
`default_nettype wire

// file: tb/pdrc_cpu_model.sv
// partner: cpu-side wishbone master for register accesses
`timescale 1ns/10ps
`default_nettype none
module pdrc_cpu_model (
  input  wire logic        clk_sys_in, // clock
  input  wire logic        ack_in,     // ack
  input  wire logic [31:0] rdat_in,    // rdata
  output var logic         cyc_out,    // cycle
  output var logic         stb_out,    // strobe
  output var logic         we_out,     // write
  output var logic [7:0]   adr_out,    // offset
  output var logic [3:0]   sel_out,    // selects
  output var logic [31:0]  dat_out     // wdata
);
  initial {cyc_out, stb_out, we_out, adr_out, sel_out, dat_out} = '0;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] dw,
                      output logic [31:0] q);
    @(posedge clk_sys_in);
    cyc_out <= 1'b1;
    stb_out <= 1'b1;
    we_out  <= w;
    adr_out <= a;
    sel_out <= 4'hf;
    dat_out <= dw;
    do @(posedge clk_sys_in); while (ack_in !== 1'b1);
    q = rdat_in;
    cyc_out <= 1'b0;
    stb_out <= 1'b0;
    adr_out <= ~a;
    dat_out <= ~dw;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dw);
    logic [31:0] q;
    xfer(1'b1, a, dw, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, q);
  endtask
  // power mode entry with timer prescale set first
  task automatic enter(input logic [7:0] m, input logic [7:0] ps);
    wr(pdrc_pkg::PDRC_OFS_BITPS, {24'h0, ps});
    wr(pdrc_pkg::PDRC_OFS_PWR, {24'h0, m});
    repeat (3) @(posedge clk_sys_in);
  endtask
endmodule
`default_nettype wire

// file: tb/testbench.sv
// testbench: scenarios for the power-down and reset block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int STAB = 20;
  localparam int FILT = 4;
  logic        clk_sys_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic        wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out;
  logic [7:0]  wb_adr_in;
  logic [3:0]  wb_sel_in;
  logic [31:0] wb_dat_in, wb_dat_out, d;
  logic        ext_reset_n_pin_in = 1'b1, por_in = 1'b0, dbg_reset_in = 1'b0;
  logic        wdt_overflow_in = 1'b0, wdt_enable_in = 1'b1;
  logic [3:0]  bod_below_in = 4'h0;
  logic        irq_pending_in = 1'b0, irq_stop_wake_in = 1'b0, global_irq_enable_in = 1'b0;
  logic        event_count_mode_in = 1'b0, bit_expired_in = 1'b0;
  logic        sys_reset_out, cpu_halt_out, osc_run_out, sys_clk_en_out, periph_clk_en_out;
  logic        timer_clk_en_out, bit_run_out, irq_vector_out;
  logic [15:0] reset_vector_out;
  logic [7:0]  bit_prescale_out;
  logic [1:0]  brownout_level_out;
  int          failures = 0, compares = 0, vecs = 0;
  pdrc_top #(.STAB_CYC(STAB), .FILT_CYC(FILT)) DUT (.*);
  pdrc_cpu_model cpu (.clk_sys_in(clk_sys_in), .ack_in(wb_ack_out), .rdat_in(wb_dat_out),
    .cyc_out(wb_cyc_in), .stb_out(wb_stb_in), .we_out(wb_we_in), .adr_out(wb_adr_in),
    .sel_out(wb_sel_in), .dat_out(wb_dat_in));
  initial forever #2.5 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) if (irq_vector_out === 1'b1) vecs++;
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] ex);
    compares++;
    if (got !== ex) begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  task automatic wait_rst(input logic v);
    int n;
    n = 0;
    while (sys_reset_out !== v && n < 100) begin
      @(posedge clk_sys_in);
      n++;
    end
  endtask
  task automatic t_regs();
    logic [7:0] ofs [5] = '{8'h87, 8'hd8, 8'h90, 8'h94, 8'h55};
    logic [7:0] rv [5] = '{8'h00, 8'h00, 8'h07, 8'h01, 8'h00};
    chk("vector", reset_vector_out, 32'h0);
    for (int i = 0; i < 5; i++) begin
      cpu.rd(ofs[i], d);
      chk("reset value", d, {24'h0, rv[i]});
    end
    cpu.wr(pdrc_pkg::PDRC_OFS_LVR, 32'h3);
    cpu.rd(pdrc_pkg::PDRC_OFS_LVR, d);
    chk("lvr", d, 32'h3);
    chk("level", brownout_level_out, 32'h3);
    cpu.wr(pdrc_pkg::PDRC_OFS_LVR, 32'h0);
    $display("t_regs done");
  endtask
  task automatic t_idle();
    int v0;
    v0 = vecs;
    global_irq_enable_in <= 1'b1;
    cpu.enter(8'h01, 8'h07);
    chk("halt", cpu_halt_out, 32'h1);
    chk("run", {osc_run_out, periph_clk_en_out, timer_clk_en_out}, 32'h7);
    cpu.rd(pdrc_pkg::PDRC_OFS_STAT, d);
    chk("state", d, 32'h2);
    irq_pending_in <= 1'b1;
    cyc(3);
    chk("halt", cpu_halt_out, 32'h0);
    irq_pending_in <= 1'b0;
    cpu.rd(pdrc_pkg::PDRC_OFS_PWR, d);
    chk("pwr", d, 32'h0);
    chk("vec", vecs - v0, 32'h1);
    $display("t_idle done");
  endtask
  task automatic t_stop();
    int v0;
    v0 = vecs;
    global_irq_enable_in <= 1'b0;
    event_count_mode_in <= 1'b1;
    cpu.enter(8'h03, 8'h5a);
    chk("prescale", bit_prescale_out, 32'h5a);
    chk("clocks", {osc_run_out, sys_clk_en_out, periph_clk_en_out, bit_run_out,
      timer_clk_en_out}, 32'h1);
    irq_pending_in <= 1'b1;
    cyc(6);
    chk("osc", osc_run_out, 32'h0);
    irq_pending_in <= 1'b0;
    irq_stop_wake_in <= 1'b1;
    cyc(3);
    irq_stop_wake_in <= 1'b0;
    chk("wake", {osc_run_out, bit_run_out, cpu_halt_out}, 32'h7);
    bit_expired_in <= 1'b1;
    cyc(3);
    bit_expired_in <= 1'b0;
    event_count_mode_in <= 1'b0;
    chk("halt", cpu_halt_out, 32'h0);
    cpu.rd(pdrc_pkg::PDRC_OFS_PWR, d);
    chk("pwr", d, 32'h0);
    chk("vec", vecs - v0, 32'h0);
    // second stop with timers not counting events and global enable set
    global_irq_enable_in <= 1'b1;
    cpu.enter(8'h03, 8'h07);
    chk("timer clk", timer_clk_en_out, 32'h0);
    irq_stop_wake_in <= 1'b1;
    cyc(3);
    irq_stop_wake_in <= 1'b0;
    bit_expired_in <= 1'b1;
    cyc(3);
    bit_expired_in <= 1'b0;
    chk("halt", cpu_halt_out, 32'h0);
    chk("vec", vecs - v0, 32'h1);
    $display("t_stop done");
  endtask
  task automatic drive(input int i, input logic v);
    case (i)
      0: ext_reset_n_pin_in <= ~v;
      1: por_in <= v;
      2: wdt_overflow_in <= v;
      3: bod_below_in <= {4{v}};
      default: dbg_reset_in <= v;
    endcase
  endtask
  task automatic t_src();
    for (int i = 0; i < 5; i++) begin
      drive(i, 1'b1);
      cyc(5 * FILT);
      chk("rst on", sys_reset_out, 32'h1);
      drive(i, 1'b0);
      wait_rst(1'b0);
      chk("rst off", sys_reset_out, 32'h0);
      cpu.rd(pdrc_pkg::PDRC_OFS_RSTF, d);
      chk("flag", d[i], 32'h1);
      cpu.wr(pdrc_pkg::PDRC_OFS_RSTF, 32'h1f);
    end
    cpu.rd(pdrc_pkg::PDRC_OFS_BITPS, d);
    chk("prescale", d, 32'h7);
    $display("t_src done");
  endtask
  task automatic t_quiet();
    wdt_enable_in <= 1'b0;
    wdt_overflow_in <= 1'b1;
    ext_reset_n_pin_in <= 1'b0;
    cyc(FILT - 1);
    ext_reset_n_pin_in <= 1'b1;
    cyc(8);
    wdt_overflow_in <= 1'b0;
    wdt_enable_in <= 1'b1;
    chk("quiet", sys_reset_out, 32'h0);
    cpu.wr(pdrc_pkg::PDRC_OFS_LVR, 32'h2);
    bod_below_in <= 4'h8;
    cyc(6);
    chk("above level", sys_reset_out, 32'h0);
    bod_below_in <= 4'hc;
    cyc(4);
    chk("below level", sys_reset_out, 32'h1);
    bod_below_in <= 4'h0;
    wait_rst(1'b0);
    cpu.rd(pdrc_pkg::PDRC_OFS_LVR, d);
    chk("lvr", d, 32'h0);
    $display("t_quiet done");
  endtask
  task automatic close_out();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    cyc(20);
    nrst_in <= 1'b1;
    wait_rst(1'b0);
    t_regs();
    t_idle();
    t_stop();
    t_src();
    t_quiet();
    close_out();
  end
  initial begin
    cyc(5000);
    failures++;
    close_out();
  end
endmodule
bind pdrc_top pdrc_chk #(.STAB_CYC(STAB_CYC), .FILT_CYC(FILT_CYC)) u_chk (.*);
`default_nettype wire

// file: verilog/pdrc_pin_filter.sv
// module: noise filter on the external reset pin
`timescale 1ns/10ps
`default_nettype none
module pdrc_pin_filter #(
  parameter int FILT_CYC = pdrc_pkg::PDRC_FILT_CYC
) (
  input  wire logic clk_sys_in,     // system clock
  input  wire logic nrst_in,        // sync reset, low
  input  wire logic pin_n_in,       // raw pin level
  output logic      filt_low_out    // filtered low
);
  typedef struct packed {
    logic [11:0] cnt;
    logic        low;
  } pdrc_filt_t;
  pdrc_filt_t s_r, s_nxt;
  always_comb begin
    s_nxt = s_r;
    if (pin_n_in) begin
      s_nxt.cnt = '0;
      s_nxt.low = 1'b0;
    end else if (s_r.cnt >= 12'(FILT_CYC - 1)) begin
      s_nxt.low = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + 12'h001;
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) s_r <= '0;
    else s_r <= s_nxt;
  end
  assign filt_low_out = s_r.low;
endmodule
`default_nettype wire

// file: verilog/pdrc_pkg.sv
// package: constants and types for the power-down and reset control block
package pdrc_pkg;
  localparam logic [7:0] PDRC_OFS_PWR   = 8'h87;
  localparam logic [7:0] PDRC_OFS_LVR   = 8'hd8;
  localparam logic [7:0] PDRC_OFS_RSTF  = 8'he8;
  localparam logic [7:0] PDRC_OFS_BITPS = 8'h90;
  localparam logic [7:0] PDRC_OFS_STAT  = 8'h94;
  localparam logic [7:0] PDRC_PWR_IDLE  = 8'h01;
  localparam logic [7:0] PDRC_PWR_STOP  = 8'h03;
  localparam logic [7:0] PDRC_PWR_RST   = 8'h00;
  localparam logic [7:0] PDRC_LVR_RST   = 8'h00;
  localparam logic [7:0] PDRC_BITPS_RST = 8'h07;
  localparam int PDRC_LVR_DIS_BIT = 7;
  localparam int PDRC_CLK_MHZ     = 200;
  localparam int PDRC_FILT_NS     = 2000;
  localparam int PDRC_FILT_CYC    = (PDRC_FILT_NS * PDRC_CLK_MHZ) / 1000;
  localparam int PDRC_STAB_MS     = 16;
  localparam int PDRC_STAB_CYC    = PDRC_STAB_MS * PDRC_CLK_MHZ * 1000;
  localparam int PDRC_SEQ_CYC     = 5;
  localparam logic [15:0] PDRC_RESET_VECTOR = 16'h0000;
  localparam int PDRC_NSRC = 5;
  localparam int PDRC_SRC_PIN = 0;
  localparam int PDRC_SRC_POR = 1;
  localparam int PDRC_SRC_WDT = 2;
  localparam int PDRC_SRC_BOD = 3;
  localparam int PDRC_SRC_DBG = 4;
  typedef enum logic [3:0] {
    PDRC_RUN  = 4'h1,
    PDRC_IDLE = 4'h2,
    PDRC_STOP = 4'h4,
    PDRC_WAKE = 4'h8
  } pdrc_pwr_t;
  typedef enum logic [2:0] {
    PDRC_R_HOLD = 3'h1,
    PDRC_R_STAB = 3'h2,
    PDRC_R_DONE = 3'h4
  } pdrc_rst_t;
endpackage

// file: verilog/pdrc_rst_if.sv
// interface: reset request and internal reset between sequencer and top
`timescale 1ns/10ps
`default_nettype none
interface pdrc_rst_if;
  logic [4:0] src;
  logic       rst_active;
  logic       seq_done;
  modport seq (input src, output rst_active, output seq_done);
  modport top (output src, input rst_active, input seq_done);
endinterface
`default_nettype wire

// file: verilog/pdrc_rst_seq.sv
// module: reset source merge, stabilisation wait and reset sequence
`timescale 1ns/10ps
`default_nettype none
module pdrc_rst_seq #(
  parameter int STAB_CYC = pdrc_pkg::PDRC_STAB_CYC
) (
  input  wire logic clk_sys_in,   // system clock
  input  wire logic nrst_in,      // sync reset, low
  pdrc_rst_if.seq   rif           // request and internal reset
);
  typedef struct packed {
    pdrc_pkg::pdrc_rst_t st;
    logic [23:0]         cnt;
    logic                act;
    logic                done;
  } pdrc_seq_t;
  pdrc_seq_t s_r, s_nxt;
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (|rif.src) begin
      s_nxt.st  = pdrc_pkg::PDRC_R_HOLD;
      s_nxt.cnt = '0;
      s_nxt.act = 1'b1;
    end else begin
      case (s_r.st)
        pdrc_pkg::PDRC_R_HOLD: begin
          s_nxt.st  = pdrc_pkg::PDRC_R_STAB;
          s_nxt.cnt = '0;
        end
        pdrc_pkg::PDRC_R_STAB: begin
          if (s_r.cnt >= 24'(STAB_CYC + pdrc_pkg::PDRC_SEQ_CYC - 1)) begin
            s_nxt.st   = pdrc_pkg::PDRC_R_DONE;
            s_nxt.act  = 1'b0;
            s_nxt.done = 1'b1;
          end else begin
            s_nxt.cnt = s_r.cnt + 24'h000001;
          end
        end
        default: s_nxt.st = pdrc_pkg::PDRC_R_DONE;
      endcase
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      s_r.st   <= pdrc_pkg::PDRC_R_HOLD;
      s_r.cnt  <= '0;
      s_r.act  <= 1'b1;
      s_r.done <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign rif.rst_active = s_r.act;
  assign rif.seq_done   = s_r.done;
endmodule
`default_nettype wire

// file: verilog/pdrc_top.sv
// top: power-down mode control, reset control and wishbone registers
// Summary of operation
// - writing 01h to the power mode register enters idle.
// - idle halts the cpu; oscillators and peripherals keep running.
// - idle ends on any reset or enabled interrupt.
// - writing 03h to the power mode register enters stop.
// - stop freezes oscillator, system and peripheral clocks; registers kept.
// - leaving stop runs the interval timer as oscillator stabilisation wait.
// - stop ends on an enabled interrupt whatever the global enable.
// - stop wakes only on reset, event counter, external, watchdog, serial.
// - in stop timers halt unless event counting; watchdog may run slow.
// - power mode register clears itself when idle or stop ends.
// - any reset restores every control register.
// - five reset sources: pin, power-on, watchdog, brown-out, debug.
// - pin low pulses shorter than about 2 us are ignored.
// - internal reset held 16 ms after the request ends.
// - reset sequence takes 5 clocks before execution.
// - execution starts at the vector held at 0000h.
// - brown-out level chosen by two-bit select among four levels.
`timescale 1ns/10ps
`default_nettype none
module pdrc_top #(
  parameter int STAB_CYC = pdrc_pkg::PDRC_STAB_CYC,
  parameter int FILT_CYC = pdrc_pkg::PDRC_FILT_CYC
) (
  input  wire logic        clk_sys_in,           // system clock
  input  wire logic        nrst_in,              // sync reset, low
  input  wire logic        wb_cyc_in,            // wishbone cycle
  input  wire logic        wb_stb_in,            // wishbone strobe
  input  wire logic        wb_we_in,             // wishbone write
  input  wire logic [7:0]  wb_adr_in,            // register offset
  input  wire logic [3:0]  wb_sel_in,            // byte selects
  input  wire logic [31:0] wb_dat_in,            // write data
  output logic [31:0]      wb_dat_out,           // read data
  output logic             wb_ack_out,           // access ack
  input  wire logic        ext_reset_n_pin_in,   // external reset pin, low
  input  wire logic        por_in,               // power-on reset request
  input  wire logic        wdt_overflow_in,      // watchdog overflow
  input  wire logic        wdt_enable_in,        // watchdog enable bit
  input  wire logic        dbg_reset_in,         // debug reset request
  input  wire logic [3:0]  bod_below_in,         // supply below each level
  input  wire logic        irq_pending_in,       // any enabled irq pending
  input  wire logic        irq_stop_wake_in,     // enabled stop-capable irq
  input  wire logic        global_irq_enable_in, // global irq enable
  input  wire logic        event_count_mode_in,  // timers in event count
  input  wire logic        bit_expired_in,       // interval timer overflow
  output logic             sys_reset_out,        // internal reset, high
  output logic [15:0]      reset_vector_out,     // start vector address
  output logic             cpu_halt_out,         // cpu halted
  output logic             osc_run_out,          // oscillator running
  output logic             sys_clk_en_out,       // system clock gate
  output logic             periph_clk_en_out,    // peripheral clock gate
  output logic             timer_clk_en_out,     // timer clock gate
  output logic             bit_run_out,          // interval timer enable
  output logic [7:0]       bit_prescale_out,     // interval timer prescale
  output logic             irq_vector_out,       // vector to isr on wake
  output logic [1:0]       brownout_level_out    // level select
);
  typedef struct packed {
    pdrc_pkg::pdrc_pwr_t     pst;
    logic [7:0]              pwr;
    logic [7:0]              lvr;
    logic [7:0]              bitps;
    logic [pdrc_pkg::PDRC_NSRC-1:0] flags;
    logic [31:0]             rdat;
    logic                    ack;
    logic                    rst;
    logic                    halt;
    logic                    osc;
    logic                    sclk;
    logic                    pclk;
    logic                    tclk;
    logic                    bitrun;
    logic                    vec;
  } pdrc_state_t;
  pdrc_state_t s_r, s_nxt;
  logic        pin_low;
  logic        bod_trip;
  logic        wr_req;
  logic        rd_req;
  logic [4:0]  src_now;
  pdrc_rst_if rif ();
  pdrc_pin_filter #(.FILT_CYC(FILT_CYC)) u_filt (
    .clk_sys_in   (clk_sys_in),
    .nrst_in      (nrst_in),
    .pin_n_in     (ext_reset_n_pin_in),
    .filt_low_out (pin_low)
  );
  pdrc_rst_seq #(.STAB_CYC(STAB_CYC)) u_seq (
    .clk_sys_in (clk_sys_in),
    .nrst_in    (nrst_in),
    .rif        (rif)
  );
  // brown-out: enabled when the disable bit reads 0
  assign bod_trip = !s_r.lvr[pdrc_pkg::PDRC_LVR_DIS_BIT]
                    && bod_below_in[s_r.lvr[1:0]];
  always_comb begin
    src_now = '0;
    src_now[pdrc_pkg::PDRC_SRC_PIN] = pin_low;
    src_now[pdrc_pkg::PDRC_SRC_POR] = por_in;
    src_now[pdrc_pkg::PDRC_SRC_WDT] = wdt_overflow_in && wdt_enable_in;
    src_now[pdrc_pkg::PDRC_SRC_BOD] = bod_trip;
    src_now[pdrc_pkg::PDRC_SRC_DBG] = dbg_reset_in;
  end
  assign rif.src = src_now;
  assign wr_req = wb_cyc_in && wb_stb_in && !s_r.ack && wb_we_in && wb_sel_in[0];
  assign rd_req = wb_cyc_in && wb_stb_in && !s_r.ack && !wb_we_in;
  always_comb begin
    s_nxt      = s_r;
    s_nxt.ack  = wb_cyc_in && wb_stb_in && !s_r.ack;
    s_nxt.vec  = 1'b0;
    s_nxt.rdat = '0;
    // power state machine
    case (s_r.pst)
      pdrc_pkg::PDRC_RUN: begin
        if (s_r.pwr == pdrc_pkg::PDRC_PWR_IDLE) begin
          s_nxt.pst = pdrc_pkg::PDRC_IDLE;
        end else if (s_r.pwr == pdrc_pkg::PDRC_PWR_STOP) begin
          s_nxt.pst = pdrc_pkg::PDRC_STOP;
        end
      end
      pdrc_pkg::PDRC_IDLE: begin
        if (irq_pending_in) begin
          s_nxt.pst = pdrc_pkg::PDRC_RUN;
          s_nxt.pwr = pdrc_pkg::PDRC_PWR_RST;
          s_nxt.vec = global_irq_enable_in;
        end
      end
      pdrc_pkg::PDRC_STOP: begin
        if (irq_stop_wake_in) begin
          s_nxt.pst = pdrc_pkg::PDRC_WAKE;
          s_nxt.pwr = pdrc_pkg::PDRC_PWR_RST;
        end
      end
      pdrc_pkg::PDRC_WAKE: begin
        if (bit_expired_in) begin
          s_nxt.pst = pdrc_pkg::PDRC_RUN;
          s_nxt.vec = global_irq_enable_in;
        end
      end
      default: s_nxt.pst = pdrc_pkg::PDRC_RUN;
    endcase
    // clock and halt gating per next state
    s_nxt.halt   = s_nxt.pst != pdrc_pkg::PDRC_RUN;
    s_nxt.osc    = s_nxt.pst != pdrc_pkg::PDRC_STOP;
    s_nxt.sclk   = s_nxt.pst != pdrc_pkg::PDRC_STOP;
    s_nxt.pclk   = s_nxt.pst == pdrc_pkg::PDRC_RUN || s_nxt.pst == pdrc_pkg::PDRC_IDLE;
    s_nxt.tclk   = s_nxt.pclk || event_count_mode_in;
    s_nxt.bitrun = s_nxt.pst != pdrc_pkg::PDRC_STOP;
    // register writes with byte select 0 set, accepted in every power state
    if (wr_req) begin
      if (wb_adr_in == pdrc_pkg::PDRC_OFS_PWR) begin
        s_nxt.pwr = wb_dat_in[7:0];
      end else if (wb_adr_in == pdrc_pkg::PDRC_OFS_LVR) begin
        s_nxt.lvr = wb_dat_in[7:0];
      end else if (wb_adr_in == pdrc_pkg::PDRC_OFS_RSTF) begin
        s_nxt.flags = s_r.flags & ~wb_dat_in[4:0];
      end else if (wb_adr_in == pdrc_pkg::PDRC_OFS_BITPS) begin
        s_nxt.bitps = wb_dat_in[7:0];
      end
    end
    s_nxt.flags = s_nxt.flags | src_now; // set wins over clear
    if (rd_req) begin
      if (wb_adr_in == pdrc_pkg::PDRC_OFS_PWR) begin
        s_nxt.rdat = {24'h000000, s_r.pwr};
      end else if (wb_adr_in == pdrc_pkg::PDRC_OFS_LVR) begin
        s_nxt.rdat = {24'h000000, s_r.lvr};
      end else if (wb_adr_in == pdrc_pkg::PDRC_OFS_RSTF) begin
        s_nxt.rdat = {27'h0000000, s_r.flags};
      end else if (wb_adr_in == pdrc_pkg::PDRC_OFS_BITPS) begin
        s_nxt.rdat = {24'h000000, s_r.bitps};
      end else if (wb_adr_in == pdrc_pkg::PDRC_OFS_STAT) begin
        s_nxt.rdat = {28'h0000000, s_r.pst};
      end else begin
        s_nxt.rdat = '0;
      end
    end
    s_nxt.rst = rif.rst_active;
    // any active internal reset restores control state
    if (rif.rst_active) begin
      s_nxt.pst   = pdrc_pkg::PDRC_RUN;
      s_nxt.pwr   = pdrc_pkg::PDRC_PWR_RST;
      s_nxt.lvr   = pdrc_pkg::PDRC_LVR_RST;
      s_nxt.bitps = pdrc_pkg::PDRC_BITPS_RST;
      s_nxt.halt  = 1'b1;
      s_nxt.vec   = 1'b0;
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      s_r.pst    <= pdrc_pkg::PDRC_RUN;
      s_r.pwr    <= pdrc_pkg::PDRC_PWR_RST;
      s_r.lvr    <= pdrc_pkg::PDRC_LVR_RST;
      s_r.bitps  <= pdrc_pkg::PDRC_BITPS_RST;
      s_r.flags  <= 5'h02;
      s_r.rdat   <= '0;
      s_r.ack    <= 1'b0;
      s_r.rst    <= 1'b1;
      s_r.halt   <= 1'b1;
      s_r.osc    <= 1'b1;
      s_r.sclk   <= 1'b1;
      s_r.pclk   <= 1'b1;
      s_r.tclk   <= 1'b1;
      s_r.bitrun <= 1'b1;
      s_r.vec    <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign wb_dat_out         = s_r.rdat;
  assign wb_ack_out         = s_r.ack;
  assign sys_reset_out      = s_r.rst;
  assign reset_vector_out   = pdrc_pkg::PDRC_RESET_VECTOR;
  assign cpu_halt_out       = s_r.halt;
  assign osc_run_out        = s_r.osc;
  assign sys_clk_en_out     = s_r.sclk;
  assign periph_clk_en_out  = s_r.pclk;
  assign timer_clk_en_out   = s_r.tclk;
  assign bit_run_out        = s_r.bitrun;
  assign bit_prescale_out   = s_r.bitps;
  assign irq_vector_out     = s_r.vec;
  assign brownout_level_out = s_r.lvr[1:0];
endmodule
`default_nettype wire
